/* File: logic/sfs_defs.vh */
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// Register numbers on the plain register port
`define SFS_A_QSTAT    4'h1
`define SFS_A_CH_FIRST 4'h2
`define SFS_A_CH_LAST  4'h5
`define SFS_A_DSTAT    4'h7
`define SFS_A_OUTCTL   4'h8
`define SFS_A_IRQ_ST   4'h9
`define SFS_A_IRQ_MSK  4'hA
`define SFS_A_MODE     4'hB

// Widths
`define SFS_AW   4
`define SFS_DW   16
`define SFS_NCH  4
`define SFS_NEV  3

// Field positions
`define SFS_B_ON       0
`define SFS_B_CPF      0
`define SFS_B_UVF      0
`define SFS_B_OVF      1
`define SFS_B_SUM      15
`define SFS_B_FAIL     0
`define SFS_EV_UV      0
`define SFS_EV_OV      1
`define SFS_EV_CP      2

// Reset values
`define SFS_RST_CMD    4'h0
`define SFS_RST_MASK   3'h0
`define SFS_RST_DATA   16'h0000

// Timing: figures in their own unit, counts derived
`define SFS_CLK_MHZ    250
`define SFS_UVOV_NS    3500
`define SFS_CP_NS      4000
`define SFS_UVOV_CYC   ((`SFS_UVOV_NS * `SFS_CLK_MHZ) / 1000)
`define SFS_CP_CYC     ((`SFS_CP_NS * `SFS_CLK_MHZ) / 1000)
`define SFS_RESTART_MS 64
`define SFS_RESTART_CYC (`SFS_RESTART_MS * `SFS_CLK_MHZ * 1000)
`define SFS_FLT_W      11
`define SFS_RS_W       24

`endif

/* File: logic/sfs_filter.v */
`default_nettype none
`include "sfs_defs.vh"

// Deglitch counter: output rises only after the input stays high N cycles
module sfs_filter #(
  parameter [`SFS_FLT_W-1:0] N = 11'h001
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire nrst,
  // Raw and filtered level
  input  wire raw,
  output reg  filt_r
);

  reg [`SFS_FLT_W-1:0] cnt_r;

  // Count restarts whenever the input drops
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 11'h000;
      filt_r <= 1'b0;
    end else if (!raw) begin
      cnt_r  <= 11'h000;
      filt_r <= 1'b0;
    end else if (cnt_r == N - 11'h001) begin
      filt_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 11'h001;
    end
  end

endmodule

`default_nettype wire

/* File: logic/sfs_top.v */
`default_nettype none
`include "sfs_defs.vh"

// Contract
// - Undervoltage lasting the filter time turns every output off.
// - Filtered undervoltage sets supply low latch and fault summary.
// - Normal mode: outputs stay off until condition gone and ON written.
// - Supply low latch clears only when condition gone and status 7 read.
// - Fail mode restarts outputs after undervoltage without host command.
// - Autorestart retries every 64 ms, between 48 and 80 ms.
// - Overvoltage sets supply high latch and fault summary.
// - Supply high latch clears only when condition gone and status 7 read.
// - Outputs held off until pump first valid; pending turn-on then executed.
// - Pump out of range past its filter time disables all outputs.
// - Filtered pump fault sets pump fault latch and fault summary.
// - Deferred turn-on executes when pump valid; inrush windows restart then.
// - Pump fault latch clears only when condition gone and status 1 read.
module sfs_top #(
  parameter [`SFS_RS_W-1:0] RESTART_CYC = `SFS_RESTART_CYC
) (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  nrst,
  // Register port
  input  wire [`SFS_AW-1:0]    reg_addr,
  input  wire [`SFS_DW-1:0]    reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [`SFS_DW-1:0]    reg_rdata,
  // Supply comparators
  input  wire                  supply_low_cmp,
  input  wire                  supply_high_cmp,
  input  wire                  pump_bad_cmp,
  // Power outputs
  output reg  [`SFS_NCH-1:0]   out_en,
  output reg  [`SFS_NCH-1:0]   inrush_restart,
  // Status
  output wire                  device_fault_summary,
  output wire                  irq
);

  ////////////////////////////////////////////////////////////////////////
  // Fault filters

  // Filter lengths in clock cycles, cut to the counter width on purpose
  localparam integer          UVOV_CYC_I = `SFS_UVOV_CYC;
  localparam integer          CP_CYC_I   = `SFS_CP_CYC;
  localparam [`SFS_FLT_W-1:0] UVOV_N     = UVOV_CYC_I[`SFS_FLT_W-1:0];
  localparam [`SFS_FLT_W-1:0] CP_N       = CP_CYC_I[`SFS_FLT_W-1:0];

  // Filtered fault levels
  wire uv_filt;
  wire ov_filt;
  wire cp_filt;

  // Undervoltage deglitch
  sfs_filter #(.N(UVOV_N)) u_uv (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw     (supply_low_cmp),
    .filt_r  (uv_filt)
  );

  // Overvoltage deglitch
  sfs_filter #(.N(UVOV_N)) u_ov (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw     (supply_high_cmp),
    .filt_r  (ov_filt)
  );

  // Pump deglitch
  sfs_filter #(.N(CP_N)) u_cp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw     (pump_bad_cmp),
    .filt_r  (cp_filt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  // Control state
  reg                  fail_mode_r;
  reg [`SFS_NCH-1:0]   cmd_on_r;
  reg [`SFS_NCH-1:0]   cmd_on_nxt;

  // Fault latches and interrupt state
  reg                  uv_lat_r;
  reg                  ov_lat_r;
  reg                  cp_lat_r;
  reg [`SFS_NEV-1:0]   irq_st_r;
  reg [`SFS_NEV-1:0]   irq_msk_r;

  // Filter edge history
  reg                  uv_q_r;
  reg                  ov_q_r;
  reg                  cp_q_r;

  // Power-up and restart tracking
  reg                  pump_up_r;
  reg                  rs_pend_r;
  reg [`SFS_RS_W-1:0]  rs_cnt_r;

  // Channel registers; index counts from the first channel register
  wire                 ch_sel;
  wire [`SFS_AW-1:0]   ch_off;
  wire [1:0]           ch_idx;
  assign ch_sel = (reg_addr >= `SFS_A_CH_FIRST) && (reg_addr <= `SFS_A_CH_LAST);
  assign ch_off = reg_addr - `SFS_A_CH_FIRST;
  assign ch_idx = ch_off[1:0];

  // Write strobes that carry ON bits
  wire wr_ch    = reg_wr && ch_sel;
  wire wr_outc  = reg_wr && (reg_addr == `SFS_A_OUTCTL);

  // Control register writes
  wire wr_mode  = reg_wr && (reg_addr == `SFS_A_MODE);
  wire wr_msk   = reg_wr && (reg_addr == `SFS_A_IRQ_MSK);
  wire wr_ist   = reg_wr && (reg_addr == `SFS_A_IRQ_ST);

  // Status reads that may clear latches
  wire rd_qst   = reg_rd && (reg_addr == `SFS_A_QSTAT);
  wire rd_dst   = reg_rd && (reg_addr == `SFS_A_DSTAT);

  // A clearing read counts only once the condition has gone
  wire uv_clr   = rd_dst && !supply_low_cmp;
  wire ov_clr   = rd_dst && !supply_high_cmp;
  wire cp_clr   = rd_qst && !pump_bad_cmp;

  // ON writes are refused while the supply is still low
  wire on_ok    = !supply_low_cmp;

  // Summary is the OR of all fault latches
  assign device_fault_summary = uv_lat_r | ov_lat_r | cp_lat_r;

  ////////////////////////////////////////////////////////////////////////
  // Mode and mask registers

  // Fail mode bit and interrupt mask
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fail_mode_r <= 1'b0;
      irq_msk_r   <= `SFS_RST_MASK;
    end else begin
      if (wr_mode)
        fail_mode_r <= reg_wdata[`SFS_B_FAIL];
      if (wr_msk)
        irq_msk_r <= reg_wdata[`SFS_NEV-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Turn-on commands

  // Commanded state; ON writes refused while undervoltage still present
  always @* begin
    cmd_on_nxt = cmd_on_r;
    if (on_ok) begin
      if (wr_ch)
        cmd_on_nxt[ch_idx] = reg_wdata[`SFS_B_ON];
      if (wr_outc)
        cmd_on_nxt = reg_wdata[`SFS_NCH-1:0];
    end
    // Normal mode forgets the command on undervoltage shutdown
    if (uv_filt && !fail_mode_r)
      cmd_on_nxt = `SFS_RST_CMD;
  end

  // Command register; commands stay remembered across pump faults
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      cmd_on_r <= `SFS_RST_CMD;
    else
      cmd_on_r <= cmd_on_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pump power-up tracking

  // Set once the pump first reads valid after reset
  // Later pump faults are left to the pump filter
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      pump_up_r <= 1'b0;
    else if (!pump_bad_cmp)
      pump_up_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Fail-mode autorestart

  // Last cycle of a retry interval
  wire rs_due = (rs_cnt_r == RESTART_CYC - 24'h000001);

  // Pending retry after an undervoltage shutdown in fail mode; the interval
  // counts from the end of the shutdown, so a long dip cannot cut it short
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rs_pend_r <= 1'b0;
      rs_cnt_r  <= {`SFS_RS_W{1'b0}};
    end else if (uv_filt && fail_mode_r) begin
      rs_pend_r <= 1'b1;
      rs_cnt_r  <= {`SFS_RS_W{1'b0}};
    end else if (!fail_mode_r) begin
      rs_pend_r <= 1'b0;
      rs_cnt_r  <= {`SFS_RS_W{1'b0}};
    end else if (rs_pend_r) begin
      if (rs_due) begin
        rs_cnt_r <= {`SFS_RS_W{1'b0}};
        // Retry succeeds only once supply is back
        if (!supply_low_cmp)
          rs_pend_r <= 1'b0;
      end else begin
        rs_cnt_r <= rs_cnt_r + 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output gating

  // Reasons to hold every output off
  wire fault_off   = uv_filt | cp_filt;
  wire startup_off = !pump_up_r;
  wire restart_off = rs_pend_r;
  wire gate_off    = fault_off | startup_off | restart_off;
  wire [`SFS_NCH-1:0] en_nxt = gate_off ? {`SFS_NCH{1'b0}} : cmd_on_r;

  // Outputs forced off by faults; restart pulse on each real turn-on
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_en         <= {`SFS_NCH{1'b0}};
      inrush_restart <= {`SFS_NCH{1'b0}};
    end else begin
      out_en         <= en_nxt;
      inrush_restart <= en_nxt & ~out_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault latches

  // Set wins over a clearing read
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uv_lat_r <= 1'b0;
      ov_lat_r <= 1'b0;
      cp_lat_r <= 1'b0;
    end else begin
      if (uv_filt)
        uv_lat_r <= 1'b1;
      else if (uv_clr)
        uv_lat_r <= 1'b0;
      if (ov_filt)
        ov_lat_r <= 1'b1;
      else if (ov_clr)
        ov_lat_r <= 1'b0;
      if (cp_filt)
        cp_lat_r <= 1'b1;
      else if (cp_clr)
        cp_lat_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  // One-cycle events on the rising edge of each filtered fault
  wire [`SFS_NEV-1:0] ev;
  assign ev[`SFS_EV_UV] = uv_filt & ~uv_q_r;
  assign ev[`SFS_EV_OV] = ov_filt & ~ov_q_r;
  assign ev[`SFS_EV_CP] = cp_filt & ~cp_q_r;

  // Edge history of filtered faults
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uv_q_r <= 1'b0;
      ov_q_r <= 1'b0;
      cp_q_r <= 1'b0;
    end else begin
      uv_q_r <= uv_filt;
      ov_q_r <= ov_filt;
      cp_q_r <= cp_filt;
    end
  end

  // Sticky status, write one to clear, new event wins
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      irq_st_r <= {`SFS_NEV{1'b0}};
    else if (wr_ist)
      irq_st_r <= (irq_st_r & ~reg_wdata[`SFS_NEV-1:0]) | ev;
    else
      irq_st_r <= irq_st_r | ev;
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_st_r & irq_msk_r);

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Registers 1 to 7 all carry the fault summary bit
  wire sum_reg = (reg_addr >= `SFS_A_QSTAT) && (reg_addr <= `SFS_A_DSTAT);

  // Next read word
  reg [`SFS_DW-1:0] rd_nxt;

  // Read mux; fault summary shown in registers 1 to 7
  always @* begin
    rd_nxt = `SFS_RST_DATA;
    if (sum_reg)
      rd_nxt[`SFS_B_SUM] = device_fault_summary;
    if (ch_sel)
      rd_nxt[`SFS_B_ON] = cmd_on_r[ch_idx];
    case (reg_addr)
      `SFS_A_QSTAT:   rd_nxt[`SFS_B_CPF] = cp_lat_r;
      `SFS_A_DSTAT: begin
        rd_nxt[`SFS_B_UVF] = uv_lat_r;
        rd_nxt[`SFS_B_OVF] = ov_lat_r;
      end
      `SFS_A_OUTCTL:  rd_nxt[`SFS_NCH-1:0] = cmd_on_r;
      `SFS_A_IRQ_ST:  rd_nxt[`SFS_NEV-1:0] = irq_st_r;
      `SFS_A_IRQ_MSK: rd_nxt[`SFS_NEV-1:0] = irq_msk_r;
      `SFS_A_MODE:    rd_nxt[`SFS_B_FAIL] = fail_mode_r;
      default:        ;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= `SFS_RST_DATA;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
    else
      reg_rdata <= `SFS_RST_DATA;
  end

endmodule

`default_nettype wire

/* File: tb/sfs_cmp_model.sv */
`default_nettype none
// Supply comparators: each line follows the requested fault a clock late
module sfs_cmp_model (
  // Clock
  input  wire logic sys_clk,
  // Requested faults
  input  wire logic lo_req,
  input  wire logic hi_req,
  input  wire logic pb_req,
  // Comparator levels
  output var logic  supply_low_cmp,
  output var logic  supply_high_cmp,
  output var logic  pump_bad_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pump starts out of range, as at power-up
  initial begin
    supply_low_cmp = 1'b0;
    supply_high_cmp = 1'b0;
    pump_bad_cmp = 1'b1;
  end
  // A condition stays until the supply recovers; reads never clear it
  always @(posedge sys_clk) begin
    supply_low_cmp <= lo_req;
    supply_high_cmp <= hi_req;
    pump_bad_cmp <= pb_req;
  end
endmodule
`default_nettype wire

/* File: tb/sfs_top_chk.sv */
`default_nettype none
// Filter, shutdown and latch timing seen at the supervisor ports
module sfs_chk #(
  parameter logic [23:0] RESTART_CYC = 24'h000032
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Read strobe and comparators
  input wire logic       reg_rd,
  input wire logic       supply_low_cmp,
  input wire logic       supply_high_cmp,
  input wire logic       pump_bad_cmp,
  // Outputs
  input wire logic [3:0] out_en,
  input wire logic [3:0] inrush_restart,
  input wire logic       device_fault_summary
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] lc_r;
  logic [10:0] hc_r;
  logic [10:0] pc_r;
  logic        pv_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  // Saturating run lengths of each comparator; pump seen valid once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lc_r <= 11'h000;
      hc_r <= 11'h000;
      pc_r <= 11'h000;
      pv_r <= 1'b0;
    end else begin
      lc_r <= supply_low_cmp ? lc_r + {10'h000, ~&lc_r} : 11'h000;
      hc_r <= supply_high_cmp ? hc_r + {10'h000, ~&hc_r} : 11'h000;
      pc_r <= pump_bad_cmp ? pc_r + {10'h000, ~&pc_r} : 11'h000;
      pv_r <= pv_r | ~pump_bad_cmp;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // A read of any register one or two cycles back
  sequence s_rd_near;
    $past(reg_rd) || $past(reg_rd, 2);
  endsequence
  property p_uv_off; lc_r >= 11'h370 |-> out_en == 4'h0; endproperty
  a_uv_off: assert property (p_uv_off) else $error("outputs on in undervoltage");
  property p_uv_sum; lc_r >= 11'h370 |-> device_fault_summary; endproperty
  a_uv_sum: assert property (p_uv_sum) else $error("no summary on undervoltage");
  property p_ov_sum; hc_r >= 11'h370 |-> device_fault_summary; endproperty
  a_ov_sum: assert property (p_ov_sum) else $error("no summary on overvoltage");
  property p_cp_off; pc_r >= 11'h3F2 |-> out_en == 4'h0; endproperty
  a_cp_off: assert property (p_cp_off) else $error("outputs on with pump bad");
  property p_cp_sum; pc_r >= 11'h3F2 |-> device_fault_summary; endproperty
  a_cp_sum: assert property (p_cp_sum) else $error("no summary on pump fault");
  property p_hold; !pv_r |-> out_en == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("outputs on before pump valid");
  property p_inrush; inrush_restart == (out_en & ~$past(out_en)); endproperty
  a_inrush: assert property (p_inrush) else $error("inrush pulse mismatch");
  property p_clr; $fell(device_fault_summary) |-> s_rd_near; endproperty
  a_clr: assert property (p_clr) else $error("latch cleared without read");
  property p_filt;
    $rose(device_fault_summary) |-> lc_r > 11'h365 || hc_r > 11'h365 || pc_r > 11'h3E2;
  endproperty
  a_filt: assert property (p_filt) else $error("fault taken before filter time");
endmodule
bind sfs_top sfs_chk #(.RESTART_CYC(RESTART_CYC)) i_sfs_chk (
  .sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .supply_low_cmp(supply_low_cmp),
  .supply_high_cmp(supply_high_cmp), .pump_bad_cmp(pump_bad_cmp), .out_en(out_en),
  .inrush_restart(inrush_restart), .device_fault_summary(device_fault_summary)
);
`default_nettype wire

/* File: tb/sfs_top_tb.sv */
`default_nettype none
// Self-checking bench for the supply fault supervisor
module sfs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        lo = 1'b0;
  logic        hi = 1'b0;
  logic        pb = 1'b1;
  logic [15:0] reg_rdata;
  logic        slc, shc, pbc, sum, irq;
  logic [3:0]  out_en, inr;
  logic [31:0] rs = 32'h2D087CC1;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  ////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  sfs_cmp_model i_sfs_cmp_model (
    .sys_clk(sys_clk), .lo_req(lo), .hi_req(hi), .pb_req(pb),
    .supply_low_cmp(slc), .supply_high_cmp(shc), .pump_bad_cmp(pbc)
  );
  sfs_top #(.RESTART_CYC(24'h000032)) i_sfs_top (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_low_cmp(slc), .supply_high_cmp(shc), .pump_bad_cmp(pbc),
    .out_en(out_en), .inrush_restart(inr), .device_fault_summary(sum), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////
  // Xorshift source
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Expected status word: summary on top, fault bits below
  function automatic logic [15:0] st(logic [1:0] f);
    return {|f, 13'h0000, f};
  endfunction
  task automatic chk(string s, logic [15:0] v, logic [15:0] e);
    checks_done++;
    if (v !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic fl(string s, logic v, logic e);
    chk(s, {15'h0000, v}, {15'h0000, e});
  endtask
  task automatic oe(logic [3:0] e);
    #1;
    chk("out_en", {12'h000, out_en}, {12'h000, e});
  endtask
  task automatic hold(int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", reg_rdata, e);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hold(10);
    nrst <= 1'b1;
    wr(4'h8, 16'h000F);
    rd(4'h8, 16'h000F);
    hold(20);
    oe(4'h0);
    pb <= 1'b0;
    hold(6);
    oe(4'hF);
    repeat (3) begin
      lo <= 1'b1;
      hold(800 + int'(rnd() & 32'h3F));
      lo <= 1'b0;
      hold(1);
    end
    oe(4'hF);
    fl("sum", sum, 1'b0);
    wr(4'hA, 16'h0007);
    lo <= 1'b1;
    hold(900);
    oe(4'h0);
    rd(4'h7, st(2'h1));
    fl("irq", irq, 1'b1);
    wr(4'h8, 16'h000F);
    rd(4'h7, st(2'h1));
    lo <= 1'b0;
    hold(5);
    oe(4'h0);
    rd(4'h7, st(2'h1));
    rd(4'h7, 16'h0000);
    wr(4'hA, 16'h0000);
    fl("irq", irq, 1'b0);
    wr(4'h9, 16'h0007);
    wr(4'hA, 16'h0007);
    fl("irq", irq, 1'b0);
    wr(4'h8, 16'h000F);
    hold(2);
    oe(4'hF);
    hi <= 1'b1;
    hold(900);
    oe(4'hF);
    rd(4'h7, st(2'h2));
    hi <= 1'b0;
    hold(3);
    rd(4'h7, st(2'h2));
    rd(4'h7, 16'h0000);
    pb <= 1'b1;
    hold(1100);
    oe(4'h0);
    rd(4'h1, st(2'h1));
    rd(4'h9, 16'h0006);
    rd(4'hA, 16'h0007);
    wr(4'h8, 16'h0005);
    pb <= 1'b0;
    hold(3);
    #1;
    chk("inrush", {12'h000, inr}, 16'h0005);
    hold(2);
    oe(4'h5);
    rd(4'h1, st(2'h1));
    rd(4'h1, 16'h0000);
    wr(4'h3, 16'h0001);
    rd(4'h3, 16'h0001);
    rd(4'h5, 16'h0000);
    hold(2);
    oe(4'h7);
    wr(4'hB, 16'h0001);
    rd(4'hB, 16'h0001);
    lo <= 1'b1;
    hold(900);
    lo <= 1'b0;
    oe(4'h0);
    n = 0;
    while (out_en !== 4'h7 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    fl("rs_gap", n > 40, 1'b1);
    oe(4'h7);
    wr(4'hB, 16'h0000);
    rd(4'h7, st(2'h1));
    rd(4'h7, 16'h0000);
    wr(4'hE, 16'(rnd()));
    rd(4'hE, 16'h0000);
    rd(4'hC, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
